/* File: src/cspc_pkg.sv */
package cspc_pkg;

  localparam logic [11:0] ADDR_SCRATCH0   = 12'he00;
  localparam logic [11:0] ADDR_SCRATCH1   = 12'he40;
  localparam logic [11:0] ADDR_PERF       = 12'hf00;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'hf80;
  localparam logic [11:0] ADDR_IRQ_MASK   = 12'hfc0;

  localparam logic [31:0] SCRATCH_RESET   = 32'h0000_0000;
  localparam logic [31:0] PERF_RESET      = 32'h0000_0000;

  localparam int NMASK_HI = 31;
  localparam int NMASK_LO = 24;
  localparam int HALT_BIT = 23;
  localparam int RUN_BIT  = 22;
  localparam int RSVD_BIT = 21;
  localparam int SEL_HI   = 20;
  localparam int SEL_LO   = 16;
  localparam int MFREQ_HI = 1;
  localparam int MFREQ_LO = 0;

  localparam int IRQ_W       = 2;
  localparam int IRQ_OVF     = 0;
  localparam int IRQ_MISS    = 1;
  localparam int STAT_RUN    = 8;

  localparam int NUM_EVENTS  = 21;
  localparam logic [4:0] EV_READ_MISS   = 5'h00;
  localparam logic [4:0] EV_BUS_READ    = 5'h0f;
  localparam logic [4:0] EV_BUS_WRITE   = 5'h10;
  localparam logic [4:0] EV_VICT_WRITE  = 5'h11;
  localparam logic [4:0] EV_LAST        = 5'h14;

  localparam int MISS_CNT_W  = 12;
  localparam int MISS_STEP   = 4;

  typedef enum logic [1:0] {
    CSPC_BUS_IDLE  = 2'b01,
    CSPC_BUS_RWAIT = 2'b10
  } cspc_bus_state_t;

endpackage : cspc_pkg

/* File: src/cspc_event_select.sv */
`timescale 1ns/1ps
module cspc_event_select (
  input  wire logic [4:0]                     sel,
  input  wire logic [cspc_pkg::NUM_EVENTS-1:0] events,
  input  wire logic [2:0]                     node_id,
  input  wire logic [7:0]                     node_mask,
  output logic                                hit
);

  logic node_ok;
  logic node_gated;

  always_comb begin
    // codes up to EV_LAST outside the node-gated trio pass through untouched; codes above EV_LAST never hit
    node_gated = (sel == cspc_pkg::EV_BUS_READ) || (sel == cspc_pkg::EV_BUS_WRITE) ||
                 (sel == cspc_pkg::EV_VICT_WRITE);
    node_ok    = node_mask[node_id];
    if (sel > cspc_pkg::EV_LAST) begin
      hit = 1'b0;
    end else begin
      hit = events[sel] && (!node_gated || node_ok);
    end
  end

endmodule : cspc_event_select

/* File: src/cspc_regs.sv */
`timescale 1ns/1ps
module cspc_regs (
  input  wire logic                             clk,
  input  wire logic                             arst_n,
  input  wire logic                             hsel,
  input  wire logic [31:0]                      haddr,
  input  wire logic [1:0]                       htrans,
  input  wire logic                             hwrite,
  input  wire logic [2:0]                       hsize,
  input  wire logic [31:0]                      hwdata,
  input  wire logic                             hready,
  output logic                                  hreadyout,
  output logic                                  hresp,
  output logic [31:0]                           hrdata,
  input  wire logic [cspc_pkg::NUM_EVENTS-1:0]  perf_events,
  input  wire logic [2:0]                       bus_node_id,
  input  wire logic                             cache_miss,
  input  wire logic                             second_counter_overflow,
  output logic                                  second_count_inc,
  output logic                                  second_counter_running,
  output logic [7:0]                            node_mask,
  output logic [4:0]                            second_counter_event_select,
  output logic                                  miss_capture_load,
  output logic                                  irq
);

  cspc_pkg::cspc_bus_state_t bus_state;

  logic [31:0]                  console_scratch_word_0;
  logic [31:0]                  console_scratch_word_1;
  logic                         reserved_zero_bit;
  logic [1:0]                   miss_freq;
  logic [cspc_pkg::IRQ_W-1:0]   irq_status;
  logic [cspc_pkg::IRQ_W-1:0]   irq_mask;
  logic [cspc_pkg::MISS_CNT_W-1:0] miss_count;

  logic                         wr_pend;
  logic [11:0]                  wr_addr;
  logic [11:0]                  rd_addr;
  logic                         rd_done;
  logic                         addr_take;
  logic                         wr_perf;
  logic                         wr_status;
  logic                         sel_hit;
  logic [cspc_pkg::MISS_CNT_W:0]   miss_interval;
  logic [cspc_pkg::MISS_CNT_W:0]   miss_next;
  logic [cspc_pkg::IRQ_W-1:0]   next_irq_status;
  logic [31:0]                  read_word;

  // hsize is not decoded: only whole-word singles are issued
  assign addr_take = hsel && htrans[1] && hready;
  assign wr_perf   = wr_pend && (wr_addr == cspc_pkg::ADDR_PERF);
  assign wr_status = wr_pend && (wr_addr == cspc_pkg::ADDR_IRQ_STATUS);

  // reads wait one cycle so a write just ahead of them is already visible
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_state <= cspc_pkg::CSPC_BUS_IDLE;
      hreadyout <= 1'b1;
      wr_pend   <= 1'b0;
      wr_addr   <= 12'h000;
      rd_addr   <= 12'h000;
      rd_done   <= 1'b0;
    end else begin
      rd_done <= 1'b0;
      unique case (bus_state)
        cspc_pkg::CSPC_BUS_IDLE: begin
          wr_pend <= addr_take && hwrite;
          wr_addr <= haddr[11:0];
          if (addr_take && !hwrite) begin
            rd_addr   <= haddr[11:0];
            hreadyout <= 1'b0;
            bus_state <= cspc_pkg::CSPC_BUS_RWAIT;
          end
        end
        cspc_pkg::CSPC_BUS_RWAIT: begin
          wr_pend   <= 1'b0;
          hreadyout <= 1'b1;
          rd_done   <= 1'b1;
          bus_state <= cspc_pkg::CSPC_BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  always_comb begin
    read_word = 32'h0000_0000;
    if (rd_addr == cspc_pkg::ADDR_SCRATCH0) begin
      read_word = console_scratch_word_0;
    end else if (rd_addr == cspc_pkg::ADDR_SCRATCH1) begin
      read_word = console_scratch_word_1;
    end else if (rd_addr == cspc_pkg::ADDR_PERF) begin
      // run and halt positions stay zero on read
      read_word[cspc_pkg::NMASK_HI:cspc_pkg::NMASK_LO] = node_mask;
      read_word[cspc_pkg::RSVD_BIT]                   = reserved_zero_bit;
      read_word[cspc_pkg::SEL_HI:cspc_pkg::SEL_LO]     = second_counter_event_select;
      read_word[cspc_pkg::MFREQ_HI:cspc_pkg::MFREQ_LO] = miss_freq;
    end else if (rd_addr == cspc_pkg::ADDR_IRQ_STATUS) begin
      read_word[cspc_pkg::IRQ_W-1:0] = irq_status;
      read_word[cspc_pkg::STAT_RUN]  = second_counter_running;
    end else if (rd_addr == cspc_pkg::ADDR_IRQ_MASK) begin
      read_word[cspc_pkg::IRQ_W-1:0] = irq_mask;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_state == cspc_pkg::CSPC_BUS_RWAIT) begin
      hrdata <= read_word;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      console_scratch_word_0 <= cspc_pkg::SCRATCH_RESET;
      console_scratch_word_1 <= cspc_pkg::SCRATCH_RESET;
    end else if (wr_pend) begin
      if (wr_addr == cspc_pkg::ADDR_SCRATCH0) begin
        console_scratch_word_0 <= hwdata;
      end
      if (wr_addr == cspc_pkg::ADDR_SCRATCH1) begin
        console_scratch_word_1 <= hwdata;
      end
    end
  end

  // bit 21 is stored as written; software is expected to keep it zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      node_mask                   <= cspc_pkg::PERF_RESET[cspc_pkg::NMASK_HI:cspc_pkg::NMASK_LO];
      reserved_zero_bit           <= cspc_pkg::PERF_RESET[cspc_pkg::RSVD_BIT];
      second_counter_event_select <= cspc_pkg::PERF_RESET[cspc_pkg::SEL_HI:cspc_pkg::SEL_LO];
      miss_freq                   <= cspc_pkg::PERF_RESET[cspc_pkg::MFREQ_HI:cspc_pkg::MFREQ_LO];
    end else if (wr_perf) begin
      node_mask                   <= hwdata[cspc_pkg::NMASK_HI:cspc_pkg::NMASK_LO];
      reserved_zero_bit           <= hwdata[cspc_pkg::RSVD_BIT];
      second_counter_event_select <= hwdata[cspc_pkg::SEL_HI:cspc_pkg::SEL_LO];
      miss_freq                   <= hwdata[cspc_pkg::MFREQ_HI:cspc_pkg::MFREQ_LO];
    end
  end

  // halt beats run when both are written together, so a write with both bits set stops counting
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      second_counter_running <= 1'b0;
    end else if (wr_perf && hwdata[cspc_pkg::HALT_BIT]) begin
      second_counter_running <= 1'b0;
    end else if (wr_perf && hwdata[cspc_pkg::RUN_BIT]) begin
      second_counter_running <= 1'b1;
    end
  end

  cspc_event_select u_second_select (
    .sel       (second_counter_event_select),
    .events    (perf_events),
    .node_id   (bus_node_id),
    .node_mask (node_mask),
    .hit       (sel_hit)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      second_count_inc <= 1'b0;
    end else begin
      second_count_inc <= second_counter_running && sel_hit;
    end
  end

  // each frequency step divides the capture rate by sixteen; the spare top bit keeps 4096 from wrapping to zero
  assign miss_interval = {{cspc_pkg::MISS_CNT_W{1'b0}}, 1'b1} << (cspc_pkg::MISS_STEP * miss_freq);
  assign miss_next     = {1'b0, miss_count} + {{cspc_pkg::MISS_CNT_W{1'b0}}, 1'b1};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      miss_count        <= '0;
      miss_capture_load <= 1'b0;
    end else begin
      miss_capture_load <= 1'b0;
      if (wr_perf) begin
        miss_count <= '0;
      end else if (cache_miss) begin
        if (miss_next >= miss_interval) begin
          miss_count        <= '0;
          miss_capture_load <= 1'b1;
        end else begin
          miss_count <= miss_next[cspc_pkg::MISS_CNT_W-1:0];
        end
      end
    end
  end

  // a new event in the clearing cycle survives the clear
  always_comb begin
    next_irq_status = irq_status;
    if (wr_status) begin
      next_irq_status = irq_status & ~hwdata[cspc_pkg::IRQ_W-1:0];
    end
    if (second_counter_overflow) begin
      next_irq_status[cspc_pkg::IRQ_OVF] = 1'b1;
    end
    if (miss_capture_load) begin
      next_irq_status[cspc_pkg::IRQ_MISS] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask <= '0;
    end else if (wr_pend && (wr_addr == cspc_pkg::ADDR_IRQ_MASK)) begin
      irq_mask <= hwdata[cspc_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_status & irq_mask);
    end
  end

  a_scratch_kept : assert property (
    @(posedge clk) disable iff (!arst_n)
    !(wr_pend && (wr_addr == cspc_pkg::ADDR_SCRATCH0)) |=> $stable(console_scratch_word_0))
    else $error("scratch word 0 changed without a write to it");

  a_scratch_readback : assert property (
    @(posedge clk) disable iff (!arst_n)
    (addr_take && !hwrite && (haddr[11:0] == cspc_pkg::ADDR_SCRATCH1))
    |=> ##1 (rd_done && hrdata == console_scratch_word_1))
    else $error("scratch word 1 read returned wrong data");

  a_halt_stops : assert property (
    @(posedge clk) disable iff (!arst_n)
    (wr_perf && hwdata[cspc_pkg::HALT_BIT]) |=> !second_counter_running ##1 !second_count_inc)
    else $error("second counter still counting after halt");

  a_run_starts : assert property (
    @(posedge clk) disable iff (!arst_n)
    (wr_perf && hwdata[cspc_pkg::RUN_BIT] && !hwdata[cspc_pkg::HALT_BIT]) |=> second_counter_running)
    else $error("second counter did not start after run");

  a_zero_no_effect : assert property (
    @(posedge clk) disable iff (!arst_n)
    (!wr_perf || (!hwdata[cspc_pkg::RUN_BIT] && !hwdata[cspc_pkg::HALT_BIT])) |=> $stable(second_counter_running))
    else $error("run state changed without a run or halt write");

  a_runhalt_read : assert property (
    @(posedge clk) disable iff (!arst_n)
    (rd_done && $past(rd_addr) == cspc_pkg::ADDR_PERF) |-> (hrdata[cspc_pkg::HALT_BIT:cspc_pkg::RUN_BIT] == 2'b00))
    else $error("run or halt bit read back nonzero");

  a_node_blocked : assert property (
    @(posedge clk) disable iff (!arst_n)
    ((second_counter_event_select == cspc_pkg::EV_BUS_READ) && !node_mask[bus_node_id]) |=> !second_count_inc)
    else $error("bus read counted for a masked-out node");

  a_node_counted : assert property (
    @(posedge clk) disable iff (!arst_n)
    (second_counter_running && (second_counter_event_select == cspc_pkg::EV_BUS_WRITE) &&
     perf_events[cspc_pkg::EV_BUS_WRITE] && node_mask[bus_node_id]) |=> second_count_inc)
    else $error("bus write from enabled node not counted");

  a_reserved_sel : assert property (
    @(posedge clk) disable iff (!arst_n)
    (second_counter_event_select > cspc_pkg::EV_LAST) |=> !second_count_inc)
    else $error("reserved select code produced a count");

  a_read_miss : assert property (
    @(posedge clk) disable iff (!arst_n)
    (second_counter_running && (second_counter_event_select == cspc_pkg::EV_READ_MISS) &&
     perf_events[cspc_pkg::EV_READ_MISS]) |=> second_count_inc)
    else $error("read miss not counted");

  a_miss_every : assert property (
    @(posedge clk) disable iff (!arst_n)
    (cache_miss && !wr_perf && (miss_freq == 2'b00)) |=> miss_capture_load)
    else $error("miss capture skipped at full rate");

  a_overflow_flag : assert property (
    @(posedge clk) disable iff (!arst_n)
    second_counter_overflow |=> irq_status[cspc_pkg::IRQ_OVF] && (irq == irq_mask[cspc_pkg::IRQ_OVF] || irq))
    else $error("overflow did not set its status bit");

endmodule : cspc_regs

/* File: sim/test_console_scratch_and_perf_control.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module test_console_scratch_and_perf_control;
  typedef struct {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] exp;
  } cspc_row_t;

  logic        clk;
  logic        arst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [20:0] perf_events;
  logic [2:0]  bus_node_id;
  logic        cache_miss;
  logic        ovf;
  logic        inc;
  logic        running;
  logic [7:0]  node_mask;
  logic [4:0]  ev_sel;
  logic        miss_load;
  logic        irq;
  int          miscompares;
  int          tests_run;
  int          inc_seen;
  int          load_seen;
  int          b;
  logic [31:0] rd;
  cspc_row_t rows[7] = '{
    '{12'he00, 32'ha5a5_5a5a, 32'ha5a5_5a5a},
    '{12'he40, 32'h1234_5678, 32'h1234_5678},
    '{12'hf00, 32'h8107_0000, 32'h8107_0000},
    '{12'hf00, 32'h00c3_0000, 32'h0003_0000},
    '{12'he04, 32'hffff_ffff, 32'h0000_0000},
    '{12'hfc0, 32'h0000_0003, 32'h0000_0003},
    '{12'he00, 32'h0bad_f00d, 32'h0bad_f00d}
  };

  assign hready = hreadyout;

  cspc_regs dut_u (
    .clk                         (clk),
    .arst_n                      (arst_n),
    .hsel                        (hsel),
    .haddr                       (haddr),
    .htrans                      (htrans),
    .hwrite                      (hwrite),
    .hsize                       (hsize),
    .hwdata                      (hwdata),
    .hready                      (hready),
    .hreadyout                   (hreadyout),
    .hresp                       (hresp),
    .hrdata                      (hrdata),
    .perf_events                 (perf_events),
    .bus_node_id                 (bus_node_id),
    .cache_miss                  (cache_miss),
    .second_counter_overflow     (ovf),
    .second_count_inc            (inc),
    .second_counter_running      (running),
    .node_mask                   (node_mask),
    .second_counter_event_select (ev_sel),
    .miss_capture_load           (miss_load),
    .irq                         (irq)
  );

  initial clk = 1'b0;
  always #2 clk = ~clk;

  // pulses are tallied from pre-edge values, so the count never races the design
  always @(posedge clk) begin
    if (inc === 1'b1) inc_seen++;
    if (miss_load === 1'b1) load_seen++;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      $display("mismatch at %0t: bus hang", $time);
    end
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {20'h0, a};
    hwrite <= wr;
    hsize  <= 3'h2;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    `CHK({hresp, rd}, {1'b0, exp})
  endtask : rdchk

  task automatic perf(input logic [7:0] m, input logic [2:0] ctl, input logic [4:0] s);
    bus(1'b1, cspc_pkg::ADDR_PERF, {m, ctl, s, 16'h0});
    // control outputs update at the write edge itself, so look only once they have settled
    @(negedge clk);
  endtask : perf

  // one event pulse, then enough idle cycles for the registered increment to show
  task automatic cnt(input logic [20:0] ev, input logic [2:0] node, input int exp);
    @(negedge clk);
    b = inc_seen;
    @(posedge clk);
    perf_events <= ev;
    bus_node_id <= node;
    @(posedge clk);
    perf_events <= 21'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK(inc_seen - b, exp)
  endtask : cnt

  task automatic misses(input int n, input int exp);
    @(negedge clk);
    b = load_seen;
    repeat (n) begin
      @(posedge clk);
      cache_miss <= 1'b1;
      @(posedge clk);
      cache_miss <= 1'b0;
    end
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK(load_seen - b, exp)
  endtask : misses

  task automatic do_reset;
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
  endtask : do_reset

  initial begin
    #200000;
    miscompares++;
    final_report();
  end

  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    perf_events = 21'h0;
    bus_node_id = 3'h0;
    cache_miss = 1'b0;
    ovf = 1'b0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, rows[i].addr, rows[i].wdata);
      rdchk(rows[i].addr, rows[i].exp);
    end
    rdchk(12'he40, 32'h1234_5678);
    $display("test register rows done");
    do_reset();
    foreach (rows[i]) rdchk(rows[i].addr, 32'h0);
    @(negedge clk);
    `CHK({running, node_mask, irq}, 10'h0)
    cnt(21'h1f_ffff, 3'h3, 0);
    $display("test reset done");
    for (int c = 0; c < 21; c++) begin
      perf(8'hff, 3'b010, c[4:0]);
      `CHK({running, ev_sel}, {1'b1, c[4:0]})
      cnt(21'h1 << c, 3'h3, 1);
      cnt(~(21'h1 << c), 3'h3, 0);
    end
    perf(8'hff, 3'b010, 5'h15);
    cnt(21'h1f_ffff, 3'h3, 0);
    $display("test event codes done");
    perf(8'h04, 3'b010, 5'h0f);
    `CHK(node_mask, 8'h04)
    cnt(21'h0_8000, 3'h2, 1);
    cnt(21'h0_8000, 3'h3, 0);
    perf(8'h81, 3'b000, 5'h11);
    `CHK(running, 1'b1)
    cnt(21'h2_0000, 3'h0, 1);
    cnt(21'h2_0000, 3'h7, 1);
    cnt(21'h2_0000, 3'h5, 0);
    perf(8'h81, 3'b100, 5'h10);
    `CHK(running, 1'b0)
    cnt(21'h1_0000, 3'h0, 0);
    perf(8'h81, 3'b000, 5'h10);
    `CHK(running, 1'b0)
    $display("test node mask and run control done");
    bus(1'b1, cspc_pkg::ADDR_IRQ_MASK, 32'h1);
    @(posedge clk);
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
    @(negedge clk);
    `CHK(irq, 1'b1)
    rdchk(cspc_pkg::ADDR_IRQ_STATUS, 32'h1);
    bus(1'b1, cspc_pkg::ADDR_IRQ_MASK, 32'h2);
    // the interrupt line follows a new mask one cycle after the write lands
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b0)
    bus(1'b1, cspc_pkg::ADDR_IRQ_STATUS, 32'h1);
    rdchk(cspc_pkg::ADDR_IRQ_STATUS, 32'h0);
    $display("test overflow interrupt done");
    bus(1'b1, cspc_pkg::ADDR_PERF, 32'h1);
    misses(15, 0);
    misses(1, 1);
    @(negedge clk);
    `CHK(irq, 1'b1)
    rdchk(cspc_pkg::ADDR_IRQ_STATUS, 32'h2);
    bus(1'b1, cspc_pkg::ADDR_PERF, 32'h0);
    misses(3, 3);
    bus(1'b1, cspc_pkg::ADDR_PERF, 32'h3);
    misses(1, 0);
    $display("test miss capture done");
    final_report();
  end
endmodule : test_console_scratch_and_perf_control
